// ### rtl/dpc_pkg.sv
// Shared constants for the digital playback control stage
package dpc_pkg;
  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'h0a;
  localparam logic [7:0] IDX_LVOL   = 8'h0b;
  localparam logic [7:0] IDX_RVOL   = 8'h0c;
  localparam logic [7:0] IDX_CFG    = 8'h0d;
  localparam logic [7:0] IDX_STATUS = 8'h0e;
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int B_MONO   = 9;
  localparam int B_SBFILT = 8;
  localparam int B_RATE   = 7;
  localparam int B_URAMP  = 6;
  localparam int B_EMPH   = 4;
  localparam int B_MUTE   = 2;
  localparam int B_APPLY  = 8;
  localparam int B_LENA   = 0;
  localparam int B_RENA   = 1;
  localparam int B_AUTO   = 2;
  localparam logic [15:0] CTRL_MASK  = 16'h03f4;
  localparam logic [15:0] CTRL_RESET = 16'h0004;
  localparam logic [7:0]  VOL_RESET  = 8'hc0;
  localparam logic [7:0]  VOL_TOP    = 8'hc0;
  localparam logic [7:0]  VOL_MUTE   = 8'h00;
  // ---------------------------------------------------------------
  // Ramp dividers in sample periods, fs/2 and fs/32
  // ---------------------------------------------------------------
  localparam logic [4:0] DIV_FAST = 5'h01;
  localparam logic [4:0] DIV_SLOW = 5'h1f;
  localparam int Q_SHIFT = 15;
  typedef enum logic [1:0] {EMPH_OFF, EMPH_32K, EMPH_44K, EMPH_48K} dpc_emph_t;
  // One 6 dB octave split into sixteen 0.375 dB mantissas
  function automatic logic [15:0] dpc_gain(input logic [7:0] code);
    logic [7:0]  att;
    logic [15:0] m;
    att = VOL_TOP - code;
    case (att[3:0])
      4'h0: m = 16'h8000;  4'h1: m = 16'h7a93;  4'h2: m = 16'h7560;
      4'h3: m = 16'h7066;  4'h4: m = 16'h6ba2;  4'h5: m = 16'h6712;
      4'h6: m = 16'h62b4;  4'h7: m = 16'h5e84;  4'h8: m = 16'h5a82;
      4'h9: m = 16'h56ac;  4'ha: m = 16'h52ff;  4'hb: m = 16'h4f7b;
      4'hc: m = 16'h4c1c;  4'hd: m = 16'h48e2;  4'he: m = 16'h45cb;
      default: m = 16'h42d5;
    endcase
    dpc_gain = (code == VOL_MUTE) ? 16'h0000 : (m >> att[7:4]);
  endfunction : dpc_gain
endpackage : dpc_pkg

// ### rtl/dpc_playback.sv
// Playback control stage with sample FIFO and Wishbone registers
// Contract
// - Codes C0h..FFh saturate at 0 dB gain
// - Soft mute ramps applied volume down stepwise
// - Unmute with ramp bit ramps up gradually
// - Unmute without ramp bit jumps to volume
// - Soft mute is set out of reset
// - Rate bit picks fs/2 or fs/32 ramp
// - Ramp ticks derive from the sample clock
// - Ramp length follows volume distance travelled
// - Mono mix sums channels at -6 dB
// - Mono only when a converter is disabled
// - Two-bit field selects de-emphasis curve
// - Filter bit selects normal or sloping filter
// - Automatic clocking overrides the filter bit
// - Control bits at 9,8,7,6,5:4,2
// - Code 00h mutes, 01h is -71.625 dB
// - Apply strobe updates both volumes together
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps

// -----------------------------------------------------------------
// Sample FIFO
// -----------------------------------------------------------------
module dpc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  wire [AW:0]       next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data_o = mem[rd_ptr];

  // Flags registered so the ready port comes from a flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      wr_ptr      <= wr_ptr + AW'(push);
      rd_ptr      <= rd_ptr + AW'(pop);
      count       <= next_count;
      in_ready_o  <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  // Storage written only while room remains
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : dpc_fifo

// -----------------------------------------------------------------
// Playback control top
// -----------------------------------------------------------------
module dpc_playback #(
  parameter int SAMPLE_W = 24,
  parameter int DEPTH    = 32,
  parameter int ADR_W    = 8,
  parameter logic [15:0] K_32K = 16'h5000,
  parameter logic [15:0] K_44K = 16'h5c00,
  parameter logic [15:0] K_48K = 16'h6000
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [ADR_W-1:0]    adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  input  wire logic                sample_tick_i,
  input  wire logic                auto_low_rate_i,
  input  wire logic                in_valid_i,
  input  wire logic [SAMPLE_W-1:0] in_left_i,
  input  wire logic [SAMPLE_W-1:0] in_right_i,
  output logic                     in_ready_o,
  output logic                     out_valid_o,
  output logic [SAMPLE_W-1:0]      out_left_o,
  output logic [SAMPLE_W-1:0]      out_right_o,
  output logic                     sloping_filter_select_o
);
  import dpc_pkg::*;
  if (SAMPLE_W < 8 || SAMPLE_W > 32 || ADR_W < 6)
  begin : g_bad
    $error("Unsupported sample or address width");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [15:0] ctrl;
  logic [7:0]  left_volume_code;
  logic [7:0]  right_volume_code;
  logic [7:0]  tgt_l;
  logic [7:0]  tgt_r;
  logic [2:0]  cfg;
  logic [7:0]  app_l;
  logic [7:0]  app_r;
  logic        ramp_up;
  logic        ramping;
  wire         req = cyc_i & stb_i & ~ack_o;
  wire         wr  = req & we_i;
  wire [7:0]   idx = 8'(adr_i[ADR_W-1:2]);
  wire         hit_ctrl = wr & (idx == IDX_CTRL);
  wire         hit_lvol = wr & (idx == IDX_LVOL);
  wire         hit_rvol = wr & (idx == IDX_RVOL);
  wire         hit_cfg  = wr & (idx == IDX_CFG);

  // Byte-lane merge, lanes 2 and 3 hold nothing
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  wire [15:0] new_ctrl = merge(ctrl, dat_i, sel_i) & CTRL_MASK;
  wire [15:0] new_lvol = merge({8'h00, left_volume_code}, dat_i, sel_i);
  wire [15:0] new_rvol = merge({8'h00, right_volume_code}, dat_i, sel_i);
  wire [15:0] new_cfg  = merge({13'h0000, cfg}, dat_i, sel_i);
  wire apply = (hit_lvol & new_lvol[B_APPLY]) | (hit_rvol & new_rvol[B_APPLY]);
  wire mute     = ctrl[B_MUTE];
  wire ramp_sel = ctrl[B_URAMP];
  wire [7:0] pend_l = hit_lvol ? new_lvol[7:0] : left_volume_code;
  wire [7:0] pend_r = hit_rvol ? new_rvol[7:0] : right_volume_code;

  // Read mux, unmapped indices read zero
  wire [31:0] rd_data =
    (idx == IDX_CTRL)   ? {16'h0000, ctrl} :
    (idx == IDX_LVOL)   ? {24'h00_0000, left_volume_code} :
    (idx == IDX_RVOL)   ? {24'h00_0000, right_volume_code} :
    (idx == IDX_CFG)    ? {29'h0000_0000, cfg} :
    (idx == IDX_STATUS) ? {14'h0000, sloping_filter_select_o, ramping, app_r, app_l} :
    32'h0000_0000;

  // One-wait-state ack, every address answered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= req ? rd_data : 32'h0000_0000;
    end
  end

  // Register storage; mute starts set so output is silent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl              <= CTRL_RESET;
      left_volume_code  <= VOL_RESET;
      right_volume_code <= VOL_RESET;
      tgt_l             <= VOL_RESET;
      tgt_r             <= VOL_RESET;
      cfg               <= 3'h0;
    end
    else
    begin
      if (hit_ctrl)
      begin
        ctrl <= new_ctrl;
      end
      if (hit_lvol)
      begin
        left_volume_code <= new_lvol[7:0];
      end
      if (hit_rvol)
      begin
        right_volume_code <= new_rvol[7:0];
      end
      if (apply)
      begin
        tgt_l <= pend_l;
        tgt_r <= pend_r;
      end
      if (hit_cfg)
      begin
        cfg <= new_cfg[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Soft mute ramp
  // ---------------------------------------------------------------
  logic [4:0] div_cnt;
  wire [4:0] div_end  = ctrl[B_RATE] ? DIV_SLOW : DIV_FAST;
  wire       ramp_tick = sample_tick_i & (div_cnt >= div_end);
  // Codes above the top code behave as 0 dB
  wire [7:0] cap_l = (tgt_l > VOL_TOP) ? VOL_TOP : tgt_l;
  wire [7:0] cap_r = (tgt_r > VOL_TOP) ? VOL_TOP : tgt_r;
  wire unmute_edge = hit_ctrl & mute & ~new_ctrl[B_MUTE];

  // Single step toward a goal, holds once reached
  function automatic logic [7:0] step(input logic [7:0] cur, input logic [7:0] goal);
    step = (cur < goal) ? cur + 8'h01 : (cur > goal) ? cur - 8'h01 : cur;
  endfunction : step

  wire [7:0] next_app_l = mute    ? step(app_l, VOL_MUTE) :
                          ramp_up ? step(app_l, cap_l) : cap_l;
  wire [7:0] next_app_r = mute    ? step(app_r, VOL_MUTE) :
                          ramp_up ? step(app_r, cap_r) : cap_r;
  wire       live_ramp  = mute | ramp_up;

  // Divider restarts at each ramp tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt <= 5'h00;
    end
    else if (sample_tick_i)
    begin
      div_cnt <= ramp_tick ? 5'h00 : div_cnt + 5'h01;
    end
  end

  // Applied volume moves one code per tick, so ramp time scales with distance
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      app_l   <= VOL_MUTE;
      app_r   <= VOL_MUTE;
      ramp_up <= 1'b0;
      ramping <= 1'b0;
    end
    else
    begin
      if (!live_ramp || ramp_tick)
      begin
        app_l <= next_app_l;
        app_r <= next_app_r;
      end
      if (unmute_edge)
      begin
        ramp_up <= new_ctrl[B_URAMP];
      end
      else if (mute || (app_l == cap_l && app_r == cap_r) || !ramp_sel)
      begin
        ramp_up <= 1'b0;
      end
      ramping <= mute ? (app_l != VOL_MUTE || app_r != VOL_MUTE) : ramp_up;
    end
  end

  // ---------------------------------------------------------------
  // Sample path
  // ---------------------------------------------------------------
  localparam int FW = 2 * SAMPLE_W;
  logic [FW-1:0] head;
  logic          head_valid;
  wire           take = head_valid & sample_tick_i;
  // Left or right converter off enables mono
  wire           both_on = cfg[B_LENA] & cfg[B_RENA];
  wire           mono_on = ctrl[B_MONO] & ~both_on;
  wire signed [SAMPLE_W-1:0] hd_l = head[FW-1:SAMPLE_W];
  wire signed [SAMPLE_W-1:0] hd_r = head[SAMPLE_W-1:0];
  // Half of the sum cannot clip
  wire signed [SAMPLE_W:0]   sum  = {hd_l[SAMPLE_W-1], hd_l} + {hd_r[SAMPLE_W-1], hd_r};
  wire signed [SAMPLE_W-1:0] mix  = sum[SAMPLE_W:1];
  wire [15:0] k_sel = (ctrl[B_EMPH+:2] == EMPH_32K) ? K_32K :
                      (ctrl[B_EMPH+:2] == EMPH_44K) ? K_44K : K_48K;
  wire        emph_on = ctrl[B_EMPH+:2] != EMPH_OFF;

  dpc_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (in_valid_i),
    .in_data_i   ({in_left_i, in_right_i}),
    .in_ready_o  (in_ready_o),
    .out_valid_o (head_valid),
    .out_data_o  (head),
    .out_ready_i (sample_tick_i)
  );

  // Both channels share gain, mix and curve logic
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic signed [SAMPLE_W-1:0] y;
    wire signed [SAMPLE_W-1:0] raw  = (ch == 0) ? hd_l : hd_r;
    wire                       ena  = cfg[ch];
    wire signed [SAMPLE_W-1:0] x    = mono_on ? mix : raw;
    wire [15:0]                g    = dpc_gain((ch == 0) ? app_l : app_r);
    wire signed [SAMPLE_W+16:0] p   = x * $signed({1'b0, g});
    wire signed [SAMPLE_W-1:0] v    = p[Q_SHIFT+SAMPLE_W-1:Q_SHIFT];
    wire signed [SAMPLE_W:0]   d    = {v[SAMPLE_W-1], v} - {y[SAMPLE_W-1], y};
    wire signed [SAMPLE_W+17:0] q   = d * $signed({1'b0, k_sel});
    // Curve is a one-pole shelf, coefficients are tunable
    wire signed [SAMPLE_W-1:0] e    = y + q[Q_SHIFT+SAMPLE_W-1:Q_SHIFT];
    wire signed [SAMPLE_W-1:0] res  = emph_on ? e : v;
    wire signed [SAMPLE_W-1:0] outv = (mono_on && !ena) ? '0 : res;

    // Settings sampled once per popped sample, never mid-sample
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        y <= '0;
      end
      else if (take)
      begin
        y <= emph_on ? e : v;
      end
    end

    if (ch == 0)
    begin : g_l
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          out_left_o <= '0;
        end
        else if (take)
        begin
          out_left_o <= outv;
        end
      end
    end
    else
    begin : g_r
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          out_right_o <= '0;
        end
        else if (take)
        begin
          out_right_o <= outv;
        end
      end
    end
  end

  // Filter choice follows clocking mode; valid pulses per sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_valid_o             <= 1'b0;
      sloping_filter_select_o <= 1'b0;
    end
    else
    begin
      out_valid_o             <= take;
      sloping_filter_select_o <= cfg[B_AUTO] ? auto_low_rate_i :
                                 ctrl[B_SBFILT];
    end
  end
endmodule : dpc_playback

// ### verif/dpc_host_src.sv
// Host-side sample source and sample-rate tick for the playback stage
`timescale 1ns/100ps
module dpc_host_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  output logic             tick_o,
  output logic             valid_o,
  output logic [23:0]      left_o,
  output logic [23:0]      right_o,
  input  wire logic        ready_i
);
  logic [1:0] div;
  int         n_late = 0;

  initial
  begin
    {tick_o, valid_o, left_o, right_o, div} = '0;
  end

  // Tick every four clocks; halting it stalls the drain side
  always @(posedge clk_i)
  begin
    div <= (rst_i || !run_i) ? div : div + 2'h1;
    tick_o <= run_i && !rst_i && div == 2'h3;
  end

  // Hold the pair until ready is seen at an edge
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    int n;
    valid_o <= 1'b1;
    left_o <= l;
    right_o <= r;
    @(posedge clk_i);
    for (n = 0; ready_i !== 1'b1 && n < 200; n++)
      @(posedge clk_i);
    n_late += int'(n == 200); // A lost handshake counts against the run
    valid_o <= 1'b0;
    left_o <= ~l; // Released lines never echo the last pair
    right_o <= ~r;
    @(posedge clk_i);
  endtask : send
endmodule : dpc_host_src

// ### verif/dpc_sva.sv
// Port-level timing checks for the playback control stage
`timescale 1ns/100ps
module dpc_sva #(
  parameter int SAMPLE_W = 24,
  parameter int DEPTH    = 32,
  parameter int ADR_W    = 8
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [ADR_W-1:0]    adr_i,
  input wire logic [3:0]          sel_i,
  input wire logic [31:0]         dat_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  input wire logic                sample_tick_i,
  input wire logic                auto_low_rate_i,
  input wire logic                in_valid_i,
  input wire logic [SAMPLE_W-1:0] in_left_i,
  input wire logic [SAMPLE_W-1:0] in_right_i,
  input wire logic                in_ready_o,
  input wire logic                out_valid_o,
  input wire logic [SAMPLE_W-1:0] out_left_o,
  input wire logic [SAMPLE_W-1:0] out_right_o,
  input wire logic                sloping_filter_select_o
);
  logic [6:0] occ;

  // Fill level rebuilt from handshakes, so the FIFO is judged from outside
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      occ <= '0;
    else
      occ <= occ + 7'(in_valid_i & in_ready_o) - 7'(sample_tick_i & (occ != 7'h00));
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_pop; sample_tick_i && occ != 7'h00; endsequence

  a_ack_next: assert property (s_req |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("data outside ack");
  a_pop_tick: assert property (s_pop |=> out_valid_o)
    else $error("tick without output");
  a_pop_none: assert property (!(sample_tick_i && occ != 7'h00) |=> !out_valid_o)
    else $error("output without pop");
  a_ready_room: assert property (in_ready_o == (occ < DEPTH))
    else $error("ready disagrees with fill");
  a_out_hold: assert property (!out_valid_o |-> $stable(out_left_o) && $stable(out_right_o))
    else $error("output moved between pops");
  a_quiet_reset: assert property ($past(rst_i) |-> !ack_o && !out_valid_o)
    else $error("activity after reset");
endmodule : dpc_sva

// ### verif/test_dpc_playback.sv
// Self-checking bench for the playback control stage
`timescale 1ns/100ps
module test_dpc_playback;
  import dpc_pkg::*;
  localparam logic [7:0] AC = 8'h28, AL = 8'h2c, AR = 8'h30, AF = 8'h34, AS = 8'h38;
  logic        clk_i, rst_i, cyc, stb, we, ack, tick, low, vld, rdy, ov, filt, run;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q;
  logic [23:0] li, ri, lo, ro, l, r;
  int          n_errors = 0;
  int          checked = 0;

  dpc_playback dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h3), .dat_i(dw), .dat_o(dr), .ack_o(ack), .sample_tick_i(tick),
    .auto_low_rate_i(low), .in_valid_i(vld), .in_left_i(li), .in_right_i(ri),
    .in_ready_o(rdy), .out_valid_o(ov), .out_left_o(lo), .out_right_o(ro),
    .sloping_filter_select_o(filt));
  dpc_host_src u_src (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .tick_o(tick),
    .valid_o(vld), .left_o(li), .right_o(ri), .ready_i(rdy));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Classic Wishbone cycle; no latency assumed, bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, 16'h0000, d};
    @(posedge clk_i);
    for (n = 0; ack !== 1'b1 && n < 20; n++)
      @(posedge clk_i);
    n_errors += int'(n == 20);
    q = dr;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic get;
    int n;
    @(posedge clk_i);
    for (n = 0; ov !== 1'b1 && n < 400; n++)
      @(posedge clk_i);
    n_errors += int'(n == 400);
    {l, r} = {lo, ro};
  endtask : get

  task automatic t_regs;
    wb(0, AC, 0);
    chk("ctrl_rst", 32'h0000_0004, q);
    wb(0, AL, 0);
    chk("lvol_rst", 32'h0000_00c0, q);
    wb(0, 8'h3c, 0);
    chk("unmapped", 32'h0000_0000, q);
    wb(1, AC, 16'hffff);
    wb(0, AC, 0);
    chk("ctrl_bits", 32'h0000_03f4, q);
    wb(1, AC, 16'h0000);
    wb(1, AF, 16'h0003);
    wb(0, AS, 0);
    chk("instant", 32'h0000_c0c0, q & 32'h0000_ffff);
  endtask : t_regs

  task automatic t_vol;
    wb(1, AL, 16'h00c5);
    wb(1, AR, 16'h01bf);
    wb(0, AS, 0);
    chk("apply_r", 32'h0000_bf00, q & 32'h0000_ff00);
    u_src.send(24'h10_0000, 24'h10_0000);
    get();
    chk("top_code", 32'h0010_0000, 32'(l));
    chk("code_bf", 32'h1, 32'(r > 24'h0f_0000 && r < 24'h10_0000));
    for (int i = 0; i < 2; i++)
    begin
      wb(1, AL, i < 1 ? 16'h0101 : 16'h0100);
      u_src.send(24'h10_0000, 24'h10_0000);
      get();
      chk("low_code", 32'h1, 32'(i < 1 ? l > 24'h00_00fd && l < 24'h00_0103 : l == 0));
    end
  endtask : t_vol

  task automatic t_ramp;
    wb(1, AL, 16'h0004);
    wb(1, AR, 16'h0104);
    wb(1, AC, 16'h0004);
    wb(0, AS, 0);
    chk("ramp_down", 32'h1, 32'(q[7:0] != 8'h00));
    repeat (60) @(posedge clk_i);
    wb(0, AS, 0);
    chk("muted", 32'h0, 32'(q[7:0]));
    wb(1, AC, 16'h00c0);
    repeat (40) @(posedge clk_i);
    wb(0, AS, 0);
    chk("slow_step", 32'h1, 32'(q[7:0] <= 8'h01));
    repeat (560) @(posedge clk_i);
    wb(0, AS, 0);
    chk("ramp_end", 32'h0000_0404, q & 32'h0001_ffff);
  endtask : t_ramp

  task automatic t_path;
    wb(1, AL, 16'h00c0);
    wb(1, AR, 16'h01c0);
    wb(1, AC, 16'h0200);
    for (int c = 1; c < 4; c++)
    begin
      wb(1, AF, 16'(c));
      u_src.send(24'h10_0000, 24'h02_0000);
      get();
      chk("mono_l", c == 3 ? 32'h10_0000 : (c == 1 ? 32'h09_0000 : 0), 32'(l));
      chk("mono_r", c == 3 ? 32'h02_0000 : (c == 2 ? 32'h09_0000 : 0), 32'(r));
    end
    for (int e = 1; e < 5; e++)
    begin
      wb(1, AC, 16'((e & 3) << 4));
      u_src.send(e[0] ? 24'h20_0000 : 24'h08_0000, 24'h00_0000);
      get();
      chk("emph", 32'(e < 4), 32'(l != (e[0] ? 24'h20_0000 : 24'h08_0000)));
    end
  endtask : t_path

  task automatic t_filt;
    for (int k = 0; k < 4; k++)
    begin
      wb(1, AF, k < 2 ? 16'h0003 : 16'h0007);
      // In auto mode the bit opposes the source, so an ignored override shows
      wb(1, AC, (k == 0 || k == 3) ? 16'h0100 : 16'h0000);
      low <= k == 2; // Low-rate source picks the sloping filter
      repeat (2) @(posedge clk_i);
      chk("filter", 32'(k == 0 || k == 2), 32'(filt));
    end
    wb(1, AF, 16'h0003);
  endtask : t_filt

  task automatic t_fifo;
    run <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 32; i++)
      u_src.send(24'(i), 24'(i));
    chk("full", 32'h0, 32'(rdy));
    run <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      get();
      chk("drain", 32'(i), 32'(l));
    end
  endtask : t_fifo

  task automatic give_verdict;
    n_errors += u_src.n_late;
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Watchdog sized well above the longest ramp plus traffic
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, dw, low, run} = '0;
    repeat (2) @(posedge clk_i);
    {rst_i, run} <= 2'b01;
    @(posedge clk_i);
    t_regs();
    t_vol();
    t_ramp();
    t_path();
    t_filt();
    t_fifo();
    give_verdict();
  end
endmodule : test_dpc_playback

bind dpc_playback dpc_sva #(.SAMPLE_W(SAMPLE_W), .DEPTH(DEPTH), .ADR_W(ADR_W)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sample_tick_i(sample_tick_i),
  .auto_low_rate_i(auto_low_rate_i), .in_valid_i(in_valid_i), .in_left_i(in_left_i),
  .in_right_i(in_right_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
  .out_left_o(out_left_o), .out_right_o(out_right_o),
  .sloping_filter_select_o(sloping_filter_select_o));
